// [shared/liniap_pkg.sv]
// constants, field layout and reset values of the indirect register port
// Summary of operation
// - Pointer at 0xD3 page 0x00, 8 bits, reset zero, selects the register.
// - A read of the window at 0xD2 returns the selected register.
// - A window write stores the byte into the selected register; status and error ignore writes.
// - Config bit 7 at 0xC9 page 0x0F enables the interface, reset 0.
// - Config bit 6 selects master when 1, slave when 0, reset 1.
// - Config bit 5 selects automatic bit rate, reset 1, slave only.
// - Configuration bits 4 to 0 read as zero and ignore writes.
// - Fifteen indirect registers sit at 0x00 to 0x0E, data bytes first.
// - Master-only bits work only in master, slave-only bits only in slave.
// - In slave, data and identifier need a pending request and an idle bus.
package liniap_pkg;

  // direct register addresses and pages
  localparam logic [7:0] SFR_PTR_ADDR  = 8'hD3;
  localparam logic [7:0] SFR_DAT_ADDR  = 8'hD2;
  localparam logic [7:0] SFR_CFG_ADDR  = 8'hC9;
  localparam logic [7:0] SFR_LIN_PAGE  = 8'h00;
  localparam logic [7:0] SFR_CFG_PAGE  = 8'h0F;

  // indirect register indices
  localparam logic [7:0] IDX_DATA_LAST = 8'h07;
  localparam logic [7:0] IDX_CTRL      = 8'h08;
  localparam logic [7:0] IDX_STAT      = 8'h09;
  localparam logic [7:0] IDX_ERR       = 8'h0A;
  localparam logic [7:0] IDX_SIZE      = 8'h0B;
  localparam logic [7:0] IDX_DIV       = 8'h0C;
  localparam logic [7:0] IDX_MUL       = 8'h0D;
  localparam logic [7:0] IDX_ID        = 8'h0E;
  localparam int         DATA_BYTES    = 8;
  localparam int         DATA_IDX_W    = 3;

  // configuration register
  localparam int         CFG_EN_BIT    = 7;
  localparam int         CFG_MODE_BIT  = 6;
  localparam int         CFG_AUTO_BIT  = 5;
  localparam logic [7:0] CFG_RESET     = 8'h60;

  // control register bits
  localparam int         CTL_STOP      = 7;
  localparam int         CTL_SLEEP     = 6;
  localparam int         CTL_TXRX      = 5;
  localparam int         CTL_DTACK     = 4;
  localparam int         CTL_RSTINT    = 3;
  localparam int         CTL_RSTERR    = 2;
  localparam int         CTL_WUPREQ    = 1;
  localparam int         CTL_STREQ     = 0;

  // status bits read by the access gate
  localparam int         STAT_ACTIVE   = 7;
  localparam int         STAT_DATA_REQ = 4;

  // access masks per mode
  localparam logic [7:0] CTL_MASTER_ONLY  = 8'h01;
  localparam logic [7:0] CTL_SLAVE_ONLY   = 8'hD0;
  localparam logic [7:0] STAT_SLAVE_ONLY  = 8'h30;
  localparam logic [7:0] ERR_SLAVE_ONLY   = 8'h18;
  localparam logic [7:0] ERR_IMPL_MASK    = 8'h1F;
  localparam logic [7:0] ALL_BITS         = 8'hFF;
  localparam logic [7:0] NO_BITS          = 8'h00;

  // size and identifier layout
  localparam int         SIZE_ENH_BIT  = 7;
  localparam int         SIZE_LEN_W    = 4;
  localparam int         ID_W          = 6;

endpackage

// [verilog/liniap_frame_buf.sv]
// eight-byte frame data buffer shared by software and the protocol engine
`timescale 1ns/100ps
module liniap_frame_buf (
  input  wire logic                                 i_clk,
  input  wire logic                                 i_nrst,
  input  wire logic                                 i_cpu_we,
  input  wire logic [liniap_pkg::DATA_IDX_W-1:0]    i_cpu_idx,
  input  wire logic [7:0]                           i_cpu_byte,
  input  wire logic                                 i_rx_we,
  input  wire logic [liniap_pkg::DATA_IDX_W-1:0]    i_rx_idx,
  input  wire logic [7:0]                           i_rx_byte,
  output logic      [7:0]                           o_sel_byte,
  output logic      [8*liniap_pkg::DATA_BYTES-1:0]  o_bytes
);

  typedef struct packed {
    logic [liniap_pkg::DATA_BYTES-1:0][7:0] b;
  } liniap_buf_t;

  liniap_buf_t st_ff;
  liniap_buf_t nxt_st;

  // engine store wins over a software store to the same byte
  always_comb begin
    nxt_st = st_ff;
    if (i_cpu_we) begin
      nxt_st.b[i_cpu_idx] = i_cpu_byte;
    end
    if (i_rx_we) begin
      nxt_st.b[i_rx_idx] = i_rx_byte;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sel_byte = st_ff.b[i_cpu_idx];

  genvar g;
  generate
    for (g = 0; g < liniap_pkg::DATA_BYTES; g++) begin : g_out
      assign o_bytes[8*g +: 8] = st_ff.b[g];
    end
  endgenerate

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  chk_buf_store: assert property (
    i_cpu_we && !(i_rx_we && i_rx_idx == i_cpu_idx)
    |=> st_ff.b[$past(i_cpu_idx)] == $past(i_cpu_byte))
    else $error("data byte not stored from window write");

endmodule

// [verilog/liniap_regs.sv]
// direct registers, pointer/window decode and indirect register bank
`timescale 1ns/100ps
module liniap_regs (
  input  wire logic                   i_clk,
  input  wire logic                   i_nrst,
  // special function register port
  input  wire logic [7:0]             i_sfr_addr,
  input  wire logic [7:0]             i_sfr_page,
  input  wire logic                   i_sfr_wr,
  input  wire logic                   i_sfr_rd,
  input  wire logic [7:0]             i_sfr_wdata,
  output logic      [7:0]             o_sfr_rdata,
  // protocol engine side
  input  wire logic [7:0]             i_frame_status,
  input  wire logic [7:0]             i_frame_error,
  input  wire logic                   i_streq_done,
  input  wire logic                   i_dtack_done,
  input  wire logic                   i_wupreq_done,
  input  wire logic                   i_rx_we,
  input  wire logic [2:0]             i_rx_idx,
  input  wire logic [7:0]             i_rx_byte,
  input  wire logic                   i_id_we,
  input  wire logic [5:0]             i_id_val,
  output logic                        o_enable,
  output logic                        o_master,
  output logic                        o_auto_bitrate,
  output logic                        o_ctrl_sleep,
  output logic                        o_ctrl_txrx,
  output logic                        o_ctrl_dtack,
  output logic                        o_ctrl_wupreq,
  output logic                        o_ctrl_streq,
  output logic                        o_stop_pulse,
  output logic                        o_rstint_pulse,
  output logic                        o_rsterr_pulse,
  output logic                        o_checksum_enh,
  output logic      [3:0]             o_frame_len,
  output logic      [7:0]             o_div,
  output logic      [7:0]             o_mul,
  output logic      [5:0]             o_id,
  output logic      [63:0]            o_data_bytes
);

  typedef struct packed {
    logic [7:0] ptr;
    logic       en;
    logic       master;
    logic       auto_sel;
    logic       auto_eff;
    logic       sleep;
    logic       txrx;
    logic       dtack;
    logic       wupreq;
    logic       streq;
    logic       stop_p;
    logic       rstint_p;
    logic       rsterr_p;
    logic       enh;
    logic [3:0] len;
    logic [7:0] div;
    logic [7:0] mul;
    logic [5:0] id;
    logic [7:0] rdata;
  } liniap_regs_t;

  liniap_regs_t st_ff;
  liniap_regs_t nxt_st;

  function automatic logic sfr_hit(input logic [7:0] addr,
                                   input logic [7:0] page,
                                   input logic [7:0] want_addr,
                                   input logic [7:0] want_page);
    sfr_hit = (addr == want_addr) && (page == want_page);
  endfunction

  // bits of the selected indirect register reachable in this mode
  function automatic logic [7:0] vis_mask(input logic [7:0] idx,
                                          input logic       master,
                                          input logic       frame_ok);
    logic [7:0] m;
    m = liniap_pkg::NO_BITS;
    if (idx <= liniap_pkg::IDX_DATA_LAST || idx == liniap_pkg::IDX_ID) begin
      m = frame_ok ? liniap_pkg::ALL_BITS : liniap_pkg::NO_BITS;
    end else if (idx == liniap_pkg::IDX_CTRL) begin
      m = master ? ~liniap_pkg::CTL_SLAVE_ONLY
                 : ~liniap_pkg::CTL_MASTER_ONLY;
    end else if (idx == liniap_pkg::IDX_STAT) begin
      m = master ? ~liniap_pkg::STAT_SLAVE_ONLY : liniap_pkg::ALL_BITS;
    end else if (idx == liniap_pkg::IDX_ERR) begin
      m = master ? ~liniap_pkg::ERR_SLAVE_ONLY : liniap_pkg::ALL_BITS;
    end else if (idx <= liniap_pkg::IDX_ID) begin
      m = liniap_pkg::ALL_BITS;
    end
    vis_mask = m;
  endfunction

  logic       hit_ptr;
  logic       hit_dat;
  logic       hit_cfg;
  logic       win_wr;
  logic       frame_ok;
  logic [7:0] vis;
  logic [7:0] wm;
  logic [7:0] wd;
  logic [7:0] buf_byte;
  logic [7:0] win_val;
  logic [7:0] cfg_val;
  logic       buf_we;

  assign hit_ptr = sfr_hit(i_sfr_addr, i_sfr_page,
                           liniap_pkg::SFR_PTR_ADDR, liniap_pkg::SFR_LIN_PAGE);
  assign hit_dat = sfr_hit(i_sfr_addr, i_sfr_page,
                           liniap_pkg::SFR_DAT_ADDR, liniap_pkg::SFR_LIN_PAGE);
  assign hit_cfg = sfr_hit(i_sfr_addr, i_sfr_page,
                           liniap_pkg::SFR_CFG_ADDR, liniap_pkg::SFR_CFG_PAGE);
  assign win_wr  = i_sfr_wr && hit_dat;
  assign frame_ok = st_ff.master ||
                    (i_frame_status[liniap_pkg::STAT_DATA_REQ] &&
                     !i_frame_status[liniap_pkg::STAT_ACTIVE]);
  assign vis     = vis_mask(st_ff.ptr, st_ff.master, frame_ok);
  assign wm      = win_wr ? vis : liniap_pkg::NO_BITS;
  assign wd      = i_sfr_wdata;
  assign buf_we  = win_wr && (st_ff.ptr <= liniap_pkg::IDX_DATA_LAST) &&
                   frame_ok;

  liniap_frame_buf u_buf (
    .i_clk      (i_clk),
    .i_nrst     (i_nrst),
    .i_cpu_we   (buf_we),
    .i_cpu_idx  (st_ff.ptr[liniap_pkg::DATA_IDX_W-1:0]),
    .i_cpu_byte (wd),
    .i_rx_we    (i_rx_we),
    .i_rx_idx   (i_rx_idx),
    .i_rx_byte  (i_rx_byte),
    .o_sel_byte (buf_byte),
    .o_bytes    (o_data_bytes)
  );

  // low configuration bits are built as zero
  assign cfg_val = {st_ff.en, st_ff.master, st_ff.auto_sel,
                    5'h00};

  // window read mux; one-shot control bits read as zero
  always_comb begin
    win_val = liniap_pkg::NO_BITS;
    if (st_ff.ptr <= liniap_pkg::IDX_DATA_LAST) begin
      win_val = buf_byte;
    end else if (st_ff.ptr == liniap_pkg::IDX_CTRL) begin
      win_val = {1'b0, st_ff.sleep, st_ff.txrx, st_ff.dtack,
                 2'h0, st_ff.wupreq, st_ff.streq};
    end else if (st_ff.ptr == liniap_pkg::IDX_STAT) begin
      win_val = i_frame_status;
    end else if (st_ff.ptr == liniap_pkg::IDX_ERR) begin
      win_val = i_frame_error & liniap_pkg::ERR_IMPL_MASK;
    end else if (st_ff.ptr == liniap_pkg::IDX_SIZE) begin
      win_val = {st_ff.enh, 3'h0, st_ff.len};
    end else if (st_ff.ptr == liniap_pkg::IDX_DIV) begin
      win_val = st_ff.div;
    end else if (st_ff.ptr == liniap_pkg::IDX_MUL) begin
      win_val = st_ff.mul;
    end else if (st_ff.ptr == liniap_pkg::IDX_ID) begin
      win_val = {2'h0, st_ff.id};
    end
    win_val = win_val & vis;
  end

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.stop_p   = 1'b0;
    nxt_st.rstint_p = 1'b0;
    nxt_st.rsterr_p = 1'b0;
    // engine clears of request bits
    if (i_streq_done) begin
      nxt_st.streq = 1'b0;
    end
    if (i_dtack_done) begin
      nxt_st.dtack = 1'b0;
    end
    if (i_wupreq_done) begin
      nxt_st.wupreq = 1'b0;
    end
    if (i_id_we) begin
      nxt_st.id = i_id_val;
    end
    if (i_sfr_wr && hit_ptr) begin
      nxt_st.ptr = wd;
    end
    if (i_sfr_wr && hit_cfg) begin
      nxt_st.en     = wd[liniap_pkg::CFG_EN_BIT];
      nxt_st.master = wd[liniap_pkg::CFG_MODE_BIT];
      nxt_st.auto_sel = wd[liniap_pkg::CFG_AUTO_BIT];
    end
    // a software write of 1 overrides an engine clear in the same cycle
    if (st_ff.ptr == liniap_pkg::IDX_CTRL) begin
      if (wm[liniap_pkg::CTL_STREQ]) begin
        nxt_st.streq = wd[liniap_pkg::CTL_STREQ];
      end
      if (wm[liniap_pkg::CTL_DTACK]) begin
        nxt_st.dtack = wd[liniap_pkg::CTL_DTACK];
      end
      if (wm[liniap_pkg::CTL_WUPREQ]) begin
        nxt_st.wupreq = wd[liniap_pkg::CTL_WUPREQ];
      end
      if (wm[liniap_pkg::CTL_SLEEP]) begin
        nxt_st.sleep = wd[liniap_pkg::CTL_SLEEP];
      end
      if (wm[liniap_pkg::CTL_TXRX]) begin
        nxt_st.txrx = wd[liniap_pkg::CTL_TXRX];
      end
      nxt_st.stop_p   = wm[liniap_pkg::CTL_STOP] && wd[liniap_pkg::CTL_STOP];
      nxt_st.rstint_p = wm[liniap_pkg::CTL_RSTINT] &&
                        wd[liniap_pkg::CTL_RSTINT];
      nxt_st.rsterr_p = wm[liniap_pkg::CTL_RSTERR] &&
                        wd[liniap_pkg::CTL_RSTERR];
    end
    if (win_wr && st_ff.ptr == liniap_pkg::IDX_SIZE) begin
      nxt_st.enh = wd[liniap_pkg::SIZE_ENH_BIT];
      nxt_st.len = wd[liniap_pkg::SIZE_LEN_W-1:0];
    end
    if (win_wr && st_ff.ptr == liniap_pkg::IDX_DIV) begin
      nxt_st.div = wd;
    end
    if (win_wr && st_ff.ptr == liniap_pkg::IDX_MUL) begin
      nxt_st.mul = wd;
    end
    if (st_ff.ptr == liniap_pkg::IDX_ID && wm != liniap_pkg::NO_BITS) begin
      nxt_st.id = wd[liniap_pkg::ID_W-1:0];
    end
    nxt_st.auto_eff = nxt_st.auto_sel && !nxt_st.master;
    if (i_sfr_rd) begin
      if (hit_ptr) begin
        nxt_st.rdata = st_ff.ptr;
      end else if (hit_dat) begin
        nxt_st.rdata = win_val;
      end else if (hit_cfg) begin
        nxt_st.rdata = cfg_val;
      end else begin
        nxt_st.rdata = liniap_pkg::NO_BITS;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_ff <= '{en:       liniap_pkg::CFG_RESET[liniap_pkg::CFG_EN_BIT],
                 master:   liniap_pkg::CFG_RESET[liniap_pkg::CFG_MODE_BIT],
                 auto_sel: liniap_pkg::CFG_RESET[liniap_pkg::CFG_AUTO_BIT],
                 default:  '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sfr_rdata    = st_ff.rdata;
  assign o_enable       = st_ff.en;
  assign o_master       = st_ff.master;
  assign o_auto_bitrate = st_ff.auto_eff;
  assign o_ctrl_sleep   = st_ff.sleep;
  assign o_ctrl_txrx    = st_ff.txrx;
  assign o_ctrl_dtack   = st_ff.dtack;
  assign o_ctrl_wupreq  = st_ff.wupreq;
  assign o_ctrl_streq   = st_ff.streq;
  assign o_stop_pulse   = st_ff.stop_p;
  assign o_rstint_pulse = st_ff.rstint_p;
  assign o_rsterr_pulse = st_ff.rsterr_p;
  assign o_checksum_enh = st_ff.enh;
  assign o_frame_len    = st_ff.len;
  assign o_div          = st_ff.div;
  assign o_mul          = st_ff.mul;
  assign o_id           = st_ff.id;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  chk_ptr_readback: assert property (
    (i_sfr_wr && hit_ptr) ##1 !(i_sfr_wr && hit_ptr)
    ##1 (i_sfr_rd && hit_ptr && !i_sfr_wr)
    |=> o_sfr_rdata == $past(i_sfr_wdata, 3))
    else $error("pointer does not read back the written value");

  chk_cfg_low_zero: assert property (
    i_sfr_rd && hit_cfg |=> o_sfr_rdata[4:0] == 5'h00)
    else $error("configuration low bits not zero");

  chk_cfg_enable: assert property (
    i_sfr_wr && hit_cfg
    |=> o_enable == $past(i_sfr_wdata[liniap_pkg::CFG_EN_BIT]))
    else $error("enable bit not taken from write");

  chk_auto_slave: assert property (
    o_master |-> !o_auto_bitrate)
    else $error("auto bit rate active in master operation");

  chk_win_range: assert property (
    i_sfr_rd && hit_dat && st_ff.ptr > liniap_pkg::IDX_ID
    |=> o_sfr_rdata == 8'h00)
    else $error("out of range window read not zero");

  chk_slave_gate: assert property (
    i_sfr_rd && hit_dat && !frame_ok &&
    (st_ff.ptr <= liniap_pkg::IDX_DATA_LAST || st_ff.ptr == liniap_pkg::IDX_ID)
    |=> o_sfr_rdata == 8'h00)
    else $error("gated frame register readable in slave");

  chk_streq_slave: assert property (
    !o_master && !o_ctrl_streq && !(i_sfr_wr && hit_cfg) |=> !o_ctrl_streq)
    else $error("start request set in slave operation");

  chk_streq_wins: assert property (
    win_wr && st_ff.master && st_ff.ptr == liniap_pkg::IDX_CTRL &&
    i_sfr_wdata[liniap_pkg::CTL_STREQ] && i_streq_done |=> o_ctrl_streq)
    else $error("start request lost against engine clear");

  chk_win_read: assert property (
    i_sfr_rd && hit_dat && st_ff.ptr == liniap_pkg::IDX_DIV
    |=> o_sfr_rdata == $past(o_div))
    else $error("window read does not show selected register");

  chk_stop_pulse: assert property (
    o_stop_pulse |-> !$past(o_master))
    else $error("stop pulse issued in master operation");

endmodule

// [dv/liniap_cpu_model.sv]
// cpu model that masters the special function register bus
`timescale 1ns/100ps
module liniap_cpu_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_page,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata
);
  initial begin
    o_addr = 8'h00;
    o_page = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'hFF;
  end
  task automatic sfr_wr(input logic [7:0] a, p, d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_page = p;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    // released data line must not keep its last value
    o_wdata = ~d;
  endtask
  task automatic sfr_rd(input logic [7:0] a, p, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_page = p;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    d = i_rdata;
  endtask
  // pointer loaded before every window access
  task automatic ind_wr(input logic [7:0] idx, d);
    sfr_wr(8'hD3, 8'h00, idx);
    sfr_wr(8'hD2, 8'h00, d);
  endtask
  task automatic ind_rd(input logic [7:0] idx, output logic [7:0] d);
    sfr_wr(8'hD3, 8'h00, idx);
    sfr_rd(8'hD2, 8'h00, d);
  endtask
endmodule

// [dv/tb_top.sv]
// self-checking bench for the indirect register port
`timescale 1ns/100ps
module tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr, page, wdata, rdata, v;
  logic        wr, rd;
  logic [7:0]  fst = 8'h00;
  logic [7:0]  fer = 8'h00;
  logic        sdone = 1'b0, ddone = 1'b0, wdone = 1'b0;
  logic        rxwe = 1'b0, idwe = 1'b0;
  logic [2:0]  rxidx = 3'h0;
  logic [7:0]  rxb = 8'h00;
  logic [5:0]  idv = 6'h00;
  logic        en, mst, aut, slp, txrx, dtk, wup, stq, stp, rsi, rse, enh;
  logic [3:0]  len;
  logic [7:0]  div, mul;
  logic [5:0]  id;
  logic [63:0] db;
  int          bad_count = 0;
  int          checks_done = 0;

  always #12.5 clk = ~clk;

  liniap_cpu_model i_cpu (
    .i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_page(page),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  liniap_regs i_liniap_regs (
    .i_clk(clk), .i_nrst(nrst), .i_sfr_addr(addr), .i_sfr_page(page),
    .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata),
    .o_sfr_rdata(rdata), .i_frame_status(fst), .i_frame_error(fer),
    .i_streq_done(sdone), .i_dtack_done(ddone), .i_wupreq_done(wdone),
    .i_rx_we(rxwe), .i_rx_idx(rxidx), .i_rx_byte(rxb), .i_id_we(idwe),
    .i_id_val(idv), .o_enable(en), .o_master(mst), .o_auto_bitrate(aut),
    .o_ctrl_sleep(slp), .o_ctrl_txrx(txrx), .o_ctrl_dtack(dtk),
    .o_ctrl_wupreq(wup), .o_ctrl_streq(stq), .o_stop_pulse(stp),
    .o_rstint_pulse(rsi), .o_rsterr_pulse(rse), .o_checksum_enh(enh),
    .o_frame_len(len), .o_div(div), .o_mul(mul), .o_id(id),
    .o_data_bytes(db));

  task automatic c8(input string n, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic c1(input string n, input logic e, g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic t_reset();
    c1("master", 1'b1, mst);
    c1("enable", 1'b0, en);
    c1("auto", 1'b0, aut);
    i_cpu.sfr_rd(8'hC9, 8'h0F, v);
    c8("config", 8'h60, v);
    i_cpu.sfr_rd(8'hD3, 8'h00, v);
    c8("pointer", 8'h00, v);
    i_cpu.sfr_rd(8'hD2, 8'h00, v);
    c8("window", 8'h00, v);
  endtask
  task automatic t_cfg();
    i_cpu.sfr_wr(8'hC9, 8'h0F, 8'hFF);
    c1("enable", 1'b1, en);
    c1("auto in master", 1'b0, aut);
    i_cpu.sfr_rd(8'hC9, 8'h0F, v);
    c8("config", 8'hE0, v);
    i_cpu.sfr_wr(8'hC9, 8'h0F, 8'h3F);
    c1("enable", 1'b0, en);
    c1("master", 1'b0, mst);
    c1("auto in slave", 1'b1, aut);
    i_cpu.sfr_rd(8'hC9, 8'h0F, v);
    c8("config", 8'h20, v);
    i_cpu.sfr_wr(8'hC9, 8'h0F, 8'hC0);
    c1("master", 1'b1, mst);
  endtask
  task automatic t_win();
    logic [7:0] fx [4] = '{8'h8F, 8'hFF, 8'hFF, 8'h3F};
    for (int i = 0; i < 8; i++) begin
      i_cpu.ind_wr(i[7:0], 8'hA0 + i[7:0]);
    end
    for (int i = 0; i < 8; i++) begin
      c8("byte out", 8'hA0 + i[7:0], db[8*i +: 8]);
      i_cpu.ind_rd(i[7:0], v);
      c8("byte read", 8'hA0 + i[7:0], v);
    end
    i_cpu.sfr_rd(8'hD2, 8'h00, v);
    c8("window again", 8'hA7, v);
    i_cpu.sfr_rd(8'hD3, 8'h00, v);
    c8("pointer", 8'h07, v);
    for (int i = 0; i < 4; i++) begin
      i_cpu.ind_wr(8'h0B + i[7:0], 8'hFF);
      i_cpu.ind_rd(8'h0B + i[7:0], v);
      c8("field read", fx[i], v);
    end
    c1("enhanced sum", 1'b1, enh);
    c8("length", 8'h0F, {4'h0, len});
    c8("divider", 8'hFF, div);
    c8("multiplier", 8'hFF, mul);
  endtask
  task automatic t_range();
    logic [7:0] pr [3] = '{8'h0F, 8'h80, 8'hFF};
    for (int i = 0; i < 3; i++) begin
      i_cpu.ind_wr(pr[i], 8'h5A);
      i_cpu.ind_rd(pr[i], v);
      c8("window beyond", 8'h00, v);
    end
    c8("byte 1", 8'hA0, db[7:0]);
    c8("identifier", 8'h3F, {2'b00, id});
    i_cpu.sfr_wr(8'hD3, 8'h0F, 8'h05);
    i_cpu.sfr_rd(8'hD3, 8'h00, v);
    c8("pointer wrong page", 8'hFF, v);
    i_cpu.sfr_wr(8'hD3, 8'h00, 8'h0C);
    i_cpu.sfr_rd(8'hD3, 8'h00, v);
    c8("pointer loaded", 8'h0C, v);
    i_cpu.sfr_rd(8'hC9, 8'h00, v);
    c8("config wrong page", 8'h00, v);
  endtask
  task automatic t_master();
    fst = 8'hFF;
    fer = 8'hFF;
    i_cpu.ind_wr(8'h08, 8'hFF);
    c1("rstint pulse", 1'b1, rsi);
    c1("rsterr pulse", 1'b1, rse);
    c1("stop pulse", 1'b0, stp);
    tick();
    c1("rstint pulse", 1'b0, rsi);
    c1("streq", 1'b1, stq);
    c1("sleep", 1'b0, slp);
    c1("dtack", 1'b0, dtk);
    c1("txrx", 1'b1, txrx);
    c1("wupreq", 1'b1, wup);
    i_cpu.ind_rd(8'h08, v);
    c8("control", 8'h23, v);
    i_cpu.ind_rd(8'h09, v);
    c8("status", 8'hCF, v);
    i_cpu.ind_rd(8'h0A, v);
    c8("error", 8'h07, v);
    sdone = 1'b1;
    wdone = 1'b1;
    tick();
    sdone = 1'b0;
    wdone = 1'b0;
    c1("streq cleared", 1'b0, stq);
    c1("wupreq cleared", 1'b0, wup);
  endtask
  task automatic t_slave();
    i_cpu.sfr_wr(8'hC9, 8'h0F, 8'hA0);
    c1("auto", 1'b1, aut);
    i_cpu.ind_rd(8'h09, v);
    c8("status", 8'hFF, v);
    i_cpu.ind_rd(8'h0A, v);
    c8("error", 8'h1F, v);
    i_cpu.ind_wr(8'h08, 8'hFF);
    c1("stop pulse", 1'b1, stp);
    c1("sleep", 1'b1, slp);
    i_cpu.ind_rd(8'h08, v);
    c8("control", 8'h72, v);
    ddone = 1'b1;
    tick();
    ddone = 1'b0;
    c1("dtack cleared", 1'b0, dtk);
    i_cpu.ind_wr(8'h00, 8'h11);
    i_cpu.ind_rd(8'h00, v);
    c8("byte closed", 8'h00, v);
    c8("byte kept", 8'hA0, db[7:0]);
    fst = 8'h10;
    i_cpu.ind_rd(8'h00, v);
    c8("byte open", 8'hA0, v);
    i_cpu.ind_wr(8'h0E, 8'h15);
    i_cpu.ind_rd(8'h0E, v);
    c8("id open", 8'h15, v);
    fst = 8'h90;
    i_cpu.ind_rd(8'h0E, v);
    c8("id closed", 8'h00, v);
    i_cpu.ind_wr(8'h01, 8'h22);
    c8("byte 2 kept", 8'hA1, db[15:8]);
    rxwe = 1'b1;
    rxidx = 3'h2;
    rxb = 8'hCC;
    idwe = 1'b1;
    idv = 6'h2A;
    tick();
    rxwe = 1'b0;
    idwe = 1'b0;
    c8("engine byte", 8'hCC, db[23:16]);
    c8("engine id", 8'h2A, {2'b00, id});
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_cfg();
    t_win();
    t_range();
    t_master();
    t_slave();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule
